// File: src/wdog_pkg.sv
package wdog_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
    localparam int          TIMEOUT_MS       = 100;
    localparam logic [15:0] MULT_RESET       = 16'h09c2;
    localparam int          TICK_EXTRA       = 2;
    localparam int          TICK_NS          = (int'(MULT_RESET) + TICK_EXTRA) * CLK_PERIOD_NS;
    localparam int          TIMER_RESET_INT  = (TIMEOUT_MS * 1_000_000) / TICK_NS;
    localparam logic [15:0] TIMER_RESET      = TIMER_RESET_INT[15:0];

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] multiplier;
        logic [15:0] sync_time;
        logic [15:0] local_time;
    } wdog_cfg_type;

    typedef struct packed {
        logic sync_expired;
        logic local_expired;
        logic outputs_safe;
    } wdog_status_type;

endpackage

// File: src/dual_comm_watchdog.sv
`timescale 1ns/1ps
// How it works
// - Two independent watchdogs, fieldbus and local interface, each defaulting to 100 ms.
// - Only a successful fieldbus process-data exchange restarts the sync-channel count.
// - Enabled sync-channel watchdog that runs out flags expiry and forces outputs FALSE.
// - Sync-channel expiry leaves the run state untouched; only outputs go safe.
// - Enabled local-interface watchdog that sees no access for its time flags expiry.
// - A base tick is multiplier plus two clock periods; the multiplier is shared, default 2498.
// - Each watchdog has its own count; its timeout is count times base tick.
// - A sync-channel count of zero disables that watchdog completely.
module dual_comm_watchdog #(
    parameter logic [15:0] MULT_DEFAULT  = wdog_pkg::MULT_RESET,
    parameter logic [15:0] SYNC_DEFAULT  = wdog_pkg::TIMER_RESET,
    parameter logic [15:0] LOCAL_DEFAULT = wdog_pkg::TIMER_RESET
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // Configuration, loaded while cfg_load is high
    input  wire logic                       cfg_load,
    input  wire wdog_pkg::wdog_cfg_type     cfg_in,
    // Traffic events
    input  wire logic                       sync_exchange_ok,
    input  wire logic                       local_access,
    // Run state and process outputs
    input  wire logic                       run_state,
    input  wire logic [7:0]                 outputs_in,
    output      logic [7:0]                 outputs_out,
    output      logic                       run_state_out,
    output      wdog_pkg::wdog_status_type  status
);

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    // Taken while cfg_load is high; a change in mid-count acts at once
    wdog_pkg::wdog_cfg_type cfg_r;
    wdog_pkg::wdog_cfg_type cfg_nxt;

    always_comb begin
        if (cfg_load) begin
            cfg_nxt = cfg_in;
        end else begin
            cfg_nxt = cfg_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_r.multiplier <= MULT_DEFAULT;
            cfg_r.sync_time  <= SYNC_DEFAULT;
            cfg_r.local_time <= LOCAL_DEFAULT;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------
    // Base tick
    // ------------------------------------------------------------
    // Free running and shared: events do not restart it, so an expiry
    // may come up to one tick before the full programmed time
    logic [16:0] pre_r;
    logic [16:0] pre_nxt;
    logic [16:0] pre_last;
    logic        tick;

    // Last prescaler value of a tick, multiplier + 1
    function automatic logic [16:0] tick_last(input logic [15:0] mult);
        logic [16:0] extra;
        extra = 17'(wdog_pkg::TICK_EXTRA - 1);
        return {1'b0, mult} + extra;
    endfunction

    // Greater-or-equal so a multiplier lowered in mid-count cannot strand it
    always_comb begin
        pre_last = tick_last(cfg_r.multiplier);
        tick     = (pre_r >= pre_last);
        if (tick) begin
            pre_nxt = 17'h00000;
        end else begin
            pre_nxt = pre_r + 17'h00001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pre_r <= 17'h00000;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // ------------------------------------------------------------
    // Watchdog step
    // ------------------------------------------------------------
    // Next count; parks at zero when disabled or restarted
    function automatic logic [15:0] wd_count(input logic [15:0] cnt,
                                             input logic        expd,
                                             input logic [15:0] limit,
                                             input logic        restart,
                                             input logic        tk);
        logic [15:0] inc;
        logic [15:0] res;
        inc = cnt + 16'h0001;
        res = cnt;
        if (limit == 16'h0000) begin
            res = 16'h0000;
        end else if (restart) begin
            res = 16'h0000;
        end else if (tk && !expd && (inc < limit)) begin
            res = inc;
        end
        return res;
    endfunction

    // Next expiry flag; a restart beats a tick in the same cycle, since
    // the link has just shown that it is alive
    function automatic logic wd_expired(input logic [15:0] cnt,
                                        input logic        expd,
                                        input logic [15:0] limit,
                                        input logic        restart,
                                        input logic        tk);
        logic [15:0] inc;
        logic        res;
        inc = cnt + 16'h0001;
        res = expd;
        if (limit == 16'h0000) begin
            res = 1'b0;
        end else if (restart) begin
            res = 1'b0;
        end else if (tk && (inc >= limit)) begin
            res = 1'b1;
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Sync-channel watchdog
    // ------------------------------------------------------------
    logic [15:0] sync_cnt_r;
    logic [15:0] sync_cnt_nxt;
    logic        sync_exp_r;
    logic        sync_exp_nxt;
    logic        sync_on;

    always_comb begin
        sync_on      = (cfg_r.sync_time != 16'h0000);
        sync_cnt_nxt = wd_count(sync_cnt_r, sync_exp_r, cfg_r.sync_time,
                                sync_exchange_ok, tick);
        sync_exp_nxt = sync_on && wd_expired(sync_cnt_r, sync_exp_r,
                                             cfg_r.sync_time,
                                             sync_exchange_ok, tick);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync_cnt_r <= 16'h0000;
            sync_exp_r <= 1'b0;
        end else begin
            sync_cnt_r <= sync_cnt_nxt;
            sync_exp_r <= sync_exp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Local-interface watchdog
    // ------------------------------------------------------------
    // Flags only; it does not touch the process outputs
    logic [15:0] local_cnt_r;
    logic [15:0] local_cnt_nxt;
    logic        local_exp_r;
    logic        local_exp_nxt;
    logic        local_on;

    always_comb begin
        local_on      = (cfg_r.local_time != 16'h0000);
        local_cnt_nxt = wd_count(local_cnt_r, local_exp_r, cfg_r.local_time,
                                 local_access, tick);
        local_exp_nxt = local_on && wd_expired(local_cnt_r, local_exp_r,
                                               cfg_r.local_time,
                                               local_access, tick);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            local_cnt_r <= 16'h0000;
            local_exp_r <= 1'b0;
        end else begin
            local_cnt_r <= local_cnt_nxt;
            local_exp_r <= local_exp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Process outputs
    // ------------------------------------------------------------
    // Uses the next flag so outputs clear on the very edge of expiry
    logic [7:0] out_r;
    logic [7:0] out_nxt;

    always_comb begin
        if (sync_exp_nxt) begin
            out_nxt = 8'h00;
        end else begin
            out_nxt = outputs_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_r <= 8'h00;
        end else begin
            out_r <= out_nxt;
        end
    end

    // ------------------------------------------------------------
    // Status and run state
    // ------------------------------------------------------------
    // Run state passes straight through; expiry never alters it
    assign outputs_out          = out_r;
    assign run_state_out        = run_state;
    assign status.sync_expired  = sync_exp_r;
    assign status.local_expired = local_exp_r;
    assign status.outputs_safe  = sync_exp_r;

endmodule // dual_comm_watchdog

// File: bench/wdog_monitor.sv
`timescale 1ns/1ps
module wdog_monitor (
    input wire logic mclk, rst_n, sync_exchange_ok, local_access, run_state, run_state_out,
    input wire logic [7:0] outputs_in, outputs_out,
    input wire wdog_pkg::wdog_cfg_type cfg_in,
    input wire wdog_pkg::wdog_status_type status
);
    logic [7:0] sq_r, lq_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Quiet spans; a zero sync time parks its span since nothing may expire then
    always_ff @(posedge mclk) begin
        sq_r <= (!rst_n || sync_exchange_ok || cfg_in.sync_time == 16'h0000) ? 8'h00 : sq_r + 8'(sq_r != 8'hff);
        lq_r <= (!rst_n || local_access) ? 8'h00 : lq_r + 8'(lq_r != 8'hff);
    end
    run_copy_a: assert property (run_state_out == run_state) else $error("run state altered");
    sync_restart_a: assert property (sync_exchange_ok |=> !status.sync_expired) else $error("no restart");
    safe_out_a: assert property (status.sync_expired |-> outputs_out == 8'h00) else $error("not safe");
    out_pass_a: assert property ($past(rst_n) && !status.sync_expired |-> outputs_out == $past(outputs_in))
        else $error("no pass");
    sync_late_a: assert property (sq_r > 8'h0c |-> status.sync_expired) else $error("sync late");
    sync_early_a: assert property ($rose(status.sync_expired) |-> sq_r > 8'h09) else $error("sync early");
    local_late_a: assert property (lq_r > 8'h0c |-> status.local_expired) else $error("local late");
    local_early_a: assert property ($rose(status.local_expired) |-> lq_r > 8'h09) else $error("local early");
    sync_off_a: assert property (cfg_in.sync_time == 16'h0000 [*3] |-> !status.sync_expired)
        else $error("sync off");
endmodule // wdog_monitor

// File: bench/far_end_model.sv
`timescale 1ns/1ps
// Master and local processor: one pulse each per four cycles while enabled
module far_end_model (
    input  wire logic mclk, sync_en, local_en,
    output logic      sync_exchange_ok, local_access
);
    logic [1:0] ph_r = 2'h0;
    initial begin
        sync_exchange_ok = 1'b0;
        local_access = 1'b0;
    end
    always @(negedge mclk) begin
        ph_r <= ph_r + 2'h1;
        sync_exchange_ok <= sync_en && ph_r == 2'h0;
        local_access <= local_en && ph_r == 2'h2;
    end
endmodule // far_end_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0, rst_n = 1'b0, run_state = 1'b0, sync_en = 1'b0, local_en = 1'b0;
    logic sync_exchange_ok, local_access, run_state_out;
    logic [7:0] outputs_in = 8'h00, outputs_out;
    logic [31:0] seed = 32'h0001_2855;
    logic [8:0] notes[$], n;
    wdog_pkg::wdog_cfg_type cfg_in = '{16'h0001, 16'h0004, 16'h0004};
    wdog_pkg::wdog_status_type status;
    int failures = 0, checks_done = 0;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial forever #20 mclk = ~mclk;
    far_end_model u_far (.mclk, .sync_en, .local_en, .sync_exchange_ok, .local_access);
    dual_comm_watchdog #(.MULT_DEFAULT(16'h0001), .SYNC_DEFAULT(16'h0004), .LOCAL_DEFAULT(16'h0004)) u_dut (
        .mclk, .rst_n, .cfg_load(1'b1), .cfg_in, .sync_exchange_ok, .local_access, .run_state,
        .outputs_in, .outputs_out, .run_state_out, .status);
    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Checks before skip are dropped: expiry moment jitters by one tick
    task automatic ph(input logic se, le, input logic [15:0] st, input int cnt, skip, input logic safe);
        for (int i = 0; i < cnt; i++) begin
            @(negedge mclk);
            seed = nx(seed);
            sync_en = se;
            local_en = le;
            cfg_in.sync_time = st;
            outputs_in = seed[7:0];
            run_state = seed[8];
            notes.push_back({i >= skip, safe ? 8'h00 : seed[7:0]});
        end
    endtask
    always @(posedge mclk) begin
        #1;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            if (n[8]) checks_done++;
            if (n[8] && outputs_out !== n[7:0]) begin
                failures++;
                $display("BAD outputs_out exp %h got %h", n[7:0], outputs_out);
            end
        end
    end
    initial begin
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        ph(1, 1, 16'h0004, 30, 0, 0);
        ph(0, 1, 16'h0004, 24, 18, 1);
        ph(1, 0, 16'h0004, 24, 6, 0);
        ph(0, 1, 16'h0000, 30, 0, 0);
        @(negedge mclk);
        end_sim;
    end
    initial begin
        #20000;
        failures++;
        end_sim;
    end
endmodule // testbench
bind dual_comm_watchdog wdog_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .sync_exchange_ok(sync_exchange_ok),
    .local_access(local_access), .run_state(run_state), .run_state_out(run_state_out), .outputs_in(outputs_in),
    .outputs_out(outputs_out), .cfg_in(cfg_in), .status(status));
